/* File: pgp_pkg.sv */
package pgp_pkg;
    localparam int NUM_PINS = 5;
    localparam logic [7:0] CMD_SET_PIN  = 8'h22;
    localparam logic [7:0] CMD_READ_PIN = 8'h23;
    localparam logic [7:0] RESP_FLAG    = 8'h40;
    localparam logic [7:0] RESP_NAK     = 8'h80;
    localparam logic [7:0] LEVEL_HIGH   = 8'h64;
    localparam logic [7:0] CFG_MAX      = 8'h0f;
    localparam logic [2:0] DRIVE_HIZ_IN = 3'b010;
    localparam logic [2:0] DRIVE_RSVD   = 3'b110;
    localparam int CLK_HZ        = 100_000_000;
    localparam int PWM_HZ        = 100;
    localparam int SAMPLE_HZ     = 32;
    // cycles per pwm percent step, and per input sample
    localparam int PWM_STEP_CYC  = CLK_HZ / (PWM_HZ * 100);
    localparam int SAMPLE_CYC    = CLK_HZ / SAMPLE_HZ;
    localparam logic [7:0] RST_LEVEL = 8'h00;
    localparam logic [3:0] RST_CFG   = 4'h2;

    typedef struct packed {
        logic       func;
        logic [2:0] drive;
    } pgp_cfg_t;

    typedef struct packed {
        logic [7:0] code;
        logic [2:0] len;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
    } pgp_cmd_t;

    typedef struct packed {
        logic [7:0] code;
        logic [2:0] len;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
    } pgp_resp_t;
endpackage : pgp_pkg

/* File: pgp_pin_drv.sv */
`timescale 1ns/1ns
module pgp_pin_drv
    import pgp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [6:0] pwm_phase,
    input  wire logic [7:0] level,
    input  wire pgp_cfg_t   cfg,
    input  wire logic       dflt_out,
    input  wire logic       dflt_oe,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            pin_pull,
    output logic            pin_slow
);
    logic       lvl;
    logic       src;
    logic       drv_o;
    logic       drv_oe;
    logic       pull;
    always_comb begin
        lvl = (level >= LEVEL_HIGH) ? 1'b1 :
              ({1'b0, pwm_phase} < level);
        src = cfg.func ? lvl : dflt_out;
        drv_o = src;
        drv_oe = 1'b0;
        pull = 1'b0;
        case (cfg.drive)
            3'b000: begin
                drv_oe = src;
                pull = ~src;
            end
            3'b001: drv_oe = 1'b1;
            3'b011: begin
                drv_oe = ~src;
                pull = src;
            end
            3'b100: drv_oe = src;
            3'b101: drv_oe = 1'b1;
            3'b111: drv_oe = ~src;
            default: drv_oe = 1'b0;
        endcase
        if (!cfg.func && !dflt_oe) begin
            drv_oe = 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out  <= 1'b0;
            pin_oe   <= 1'b0;
            pin_pull <= 1'b0;
            pin_slow <= 1'b0;
        end else begin
            pin_out  <= drv_o;
            pin_oe   <= drv_oe;
            pin_pull <= pull;
            pin_slow <= cfg.drive[2];
        end
    end
endmodule : pgp_pin_drv

/* File: pgp_gpio_port.sv */
`timescale 1ns/1ns
module pgp_gpio_port
    import pgp_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYC,
    parameter int STEP_DIV   = PWM_STEP_CYC
)(
    // clock and reset
    input  wire logic                CLK,
    input  wire logic                RST,
    // command in
    input  wire logic                CMD_VALID,
    input  wire pgp_cmd_t            CMD,
    // response out
    output pgp_resp_t                RESP,
    output logic                     RESP_VALID,
    // boot state
    input  wire logic                BOOT_LOAD,
    input  wire logic [NUM_PINS-1:0][7:0] BOOT_LEVEL,
    input  wire logic [NUM_PINS-1:0][3:0] BOOT_CFG,
    output logic [NUM_PINS-1:0][7:0] SAVE_LEVEL,
    output logic [NUM_PINS-1:0][3:0] SAVE_CFG,
    // default roles
    input  wire logic [NUM_PINS-1:0] DFLT_OUT,
    input  wire logic [NUM_PINS-1:0] DFLT_OE,
    output logic [NUM_PINS-1:0]      SAMPLE_LVL,
    // pins
    input  wire logic [NUM_PINS-1:0] PIN_I,
    output logic [NUM_PINS-1:0]      PIN_O,
    output logic [NUM_PINS-1:0]      PIN_OE,
    output logic [NUM_PINS-1:0]      PIN_PULL,
    output logic [NUM_PINS-1:0]      PIN_SLOW
);
    logic [NUM_PINS-1:0][7:0] level_r;
    pgp_cfg_t [NUM_PINS-1:0]  cfg_r;
    logic [NUM_PINS-1:0]      samp_r;
    logic [NUM_PINS-1:0]      rise_r;
    logic [NUM_PINS-1:0]      fall_r;
    logic [31:0]              samp_cnt_r;
    logic [31:0]              step_cnt_r;
    logic [6:0]               phase_r;
    logic                     tick;
    logic                     set_ok;
    logic                     set_cmd;
    logic                     rd_cmd;
    logic                     rd_ok;
    logic [2:0]               idx;
    logic [NUM_PINS-1:0]      rd_hit;
    logic                     samp_vld_r;
    logic [NUM_PINS-1:0]      rise_ev;
    logic [NUM_PINS-1:0]      fall_ev;

    assign idx = CMD.d0[2:0];
    assign set_cmd = CMD_VALID && CMD.code == CMD_SET_PIN;
    assign rd_cmd  = CMD_VALID && CMD.code == CMD_READ_PIN;
    // reject bad index, level or config
    assign set_ok = set_cmd && CMD.d0 < 8'(NUM_PINS)
                 && CMD.d1 <= LEVEL_HIGH
                 && (CMD.len == 3'd2 || (CMD.len == 3'd3
                     && CMD.d2 <= CFG_MAX
                     && CMD.d2[2:0] != DRIVE_RSVD));
    assign rd_ok = rd_cmd && CMD.len == 3'd1 && CMD.d0 < 8'(NUM_PINS);
    assign tick = samp_cnt_r == 32'(SAMPLE_DIV - 1);
    // first sample has no predecessor, so no edge from reset value
    assign rise_ev = (tick && samp_vld_r) ? (PIN_I & ~samp_r) : '0;
    assign fall_ev = (tick && samp_vld_r) ? (~PIN_I & samp_r) : '0;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) samp_cnt_r <= '0;
        else samp_cnt_r <= tick ? '0 : samp_cnt_r + 32'd1;
    end

    // arm edge capture after first sample
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) samp_vld_r <= 1'b0;
        else if (tick) samp_vld_r <= 1'b1;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            step_cnt_r <= '0;
            phase_r    <= '0;
        end else if (step_cnt_r == 32'(STEP_DIV - 1)) begin
            step_cnt_r <= '0;
            phase_r    <= (phase_r == 7'd99) ? 7'd0 : phase_r + 7'd1;
        end else begin
            step_cnt_r <= step_cnt_r + 32'd1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                level_r[i] <= RST_LEVEL;
                cfg_r[i]   <= RST_CFG;
            end
        end else if (BOOT_LOAD) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                level_r[i] <= BOOT_LEVEL[i];
                cfg_r[i]   <= BOOT_CFG[i];
            end
        end else if (set_ok) begin
            level_r[idx] <= CMD.d1;
            if (CMD.len == 3'd3) cfg_r[idx] <= CMD.d2[3:0];
        end
    end

    // edge flags only cleared by read or reset
    always_comb begin
        rd_hit = '0;
        if (rd_ok) rd_hit[idx] = 1'b1;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            samp_r <= '0;
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            if (tick) samp_r <= PIN_I;
            for (int i = 0; i < NUM_PINS; i++) begin
                if (rise_ev[i]) rise_r[i] <= 1'b1;
                else if (rd_hit[i]) rise_r[i] <= 1'b0;
                if (fall_ev[i]) fall_r[i] <= 1'b1;
                else if (rd_hit[i]) fall_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RESP       <= '0;
            RESP_VALID <= 1'b0;
        end else begin
            RESP_VALID <= set_cmd || rd_cmd;
            if (set_ok) begin
                RESP <= '{CMD_SET_PIN | RESP_FLAG, 3'd0, 8'h00, 8'h00,
                          8'h00, 8'h00};
            end else if (rd_ok) begin
                RESP <= '{CMD_READ_PIN | RESP_FLAG, 3'd4, CMD.d0,
                          {5'd0, rise_r[idx], fall_r[idx], samp_r[idx]},
                          level_r[idx], {4'd0, cfg_r[idx]}};
            end else if (set_cmd || rd_cmd) begin
                RESP <= '{CMD.code | RESP_NAK, 3'd0, 8'h00, 8'h00,
                          8'h00, 8'h00};
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SAVE_LEVEL <= '0;
            SAVE_CFG   <= '0;
            SAMPLE_LVL <= '0;
        end else begin
            SAMPLE_LVL <= samp_r;
            for (int i = 0; i < NUM_PINS; i++) begin
                SAVE_LEVEL[i] <= level_r[i];
                SAVE_CFG[i]   <= cfg_r[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            pgp_pin_drv u_drv (
                .clk      (CLK),
                .rst      (RST),
                .pwm_phase(phase_r),
                .level    (level_r[g]),
                .cfg      (cfg_r[g]),
                .dflt_out (DFLT_OUT[g]),
                .dflt_oe  (DFLT_OE[g]),
                .pin_out  (PIN_O[g]),
                .pin_oe   (PIN_OE[g]),
                .pin_pull (PIN_PULL[g]),
                .pin_slow (PIN_SLOW[g])
            );
        end
    endgenerate

    property p_set_ack;
        @(posedge CLK) disable iff (RST)
        set_ok |=> RESP_VALID && RESP.code == 8'h62 && RESP.len == 3'd0;
    endproperty
    a_set_ack: assert property (p_set_ack) else $error("bad set ack");
    property p_reject;
        @(posedge CLK) disable iff (RST)
        (set_cmd && !set_ok && !BOOT_LOAD) |=> $stable(level_r)
            && $stable(cfg_r);
    endproperty
    a_reject: assert property (p_reject) else $error("bad set changed");
    property p_two_byte;
        @(posedge CLK) disable iff (RST)
        (set_ok && CMD.len == 3'd2 && !BOOT_LOAD) |=> $stable(cfg_r);
    endproperty
    a_two_byte: assert property (p_two_byte) else $error("cfg changed");
    property p_rise;
        @(posedge CLK) disable iff (RST)
        (tick && samp_vld_r && PIN_I[0] && !samp_r[0]) |=> rise_r[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rise missed");
    property p_clear;
        @(posedge CLK) disable iff (RST)
        (rd_hit[0] && !tick) |=> !rise_r[0] && !fall_r[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flags kept");
    property p_rd_reply;
        @(posedge CLK) disable iff (RST)
        rd_ok |=> RESP.code == 8'h63 && RESP.d2 <= LEVEL_HIGH
            && RESP.d3[7:4] == 4'd0;
    endproperty
    a_rd_reply: assert property (p_rd_reply) else $error("bad read");
    property p_samp_hold;
        @(posedge CLK) disable iff (RST)
        !tick |=> $stable(samp_r);
    endproperty
    a_samp_hold: assert property (p_samp_hold) else $error("sampled");
    property p_bad_idx;
        @(posedge CLK) disable iff (RST)
        (set_cmd && CMD.d0 > 8'd4) |-> !set_ok;
    endproperty
    a_bad_idx: assert property (p_bad_idx) else $error("bad index");
    property p_rd_status;
        @(posedge CLK) disable iff (RST)
        rd_ok |=> RESP.len == 3'd4 && RESP.d0 == $past(CMD.d0)
            && RESP.d1[7:3] == 5'd0;
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status");
    property p_rd_sample;
        @(posedge CLK) disable iff (RST)
        rd_ok |=> RESP.d1[0] == $past(samp_r[idx]);
    endproperty
    a_rd_sample: assert property (p_rd_sample) else $error("level");
    property p_rd_level;
        @(posedge CLK) disable iff (RST)
        rd_ok |=> RESP.d2 == $past(level_r[idx]);
    endproperty
    a_rd_level: assert property (p_rd_level) else $error("duty");
    property p_nak;
        @(posedge CLK) disable iff (RST)
        (set_cmd && !set_ok) |=> RESP_VALID && RESP.code == 8'ha2
            && RESP.len == 3'd0;
    endproperty
    a_nak: assert property (p_nak) else $error("no refusal");
    property p_phase;
        @(posedge CLK) disable iff (RST)
        phase_r <= 7'd99;
    endproperty
    a_phase: assert property (p_phase) else $error("phase range");
    property p_first;
        @(posedge CLK) disable iff (RST)
        !samp_vld_r |-> rise_r == '0 && fall_r == '0;
    endproperty
    a_first: assert property (p_first) else $error("early edge");
    property p_rd_quiet;
        @(posedge CLK) disable iff (RST)
        (rd_cmd && !BOOT_LOAD) |=> $stable(level_r) && $stable(cfg_r);
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read wrote");
    property p_boot;
        @(posedge CLK) disable iff (RST)
        BOOT_LOAD |=> level_r == $past(BOOT_LEVEL)
            && cfg_r == $past(BOOT_CFG);
    endproperty
    a_boot: assert property (p_boot) else $error("boot load");
    property p_set_write;
        @(posedge CLK) disable iff (RST)
        (set_ok && !BOOT_LOAD) |=> level_r[$past(idx)] == $past(CMD.d1);
    endproperty
    a_set_write: assert property (p_set_write) else $error("no write");
    c_set: cover property (@(posedge CLK) set_ok);
    c_read: cover property (@(posedge CLK) rd_ok && rise_r[idx]);
    c_rej: cover property (@(posedge CLK) set_cmd && !set_ok);
    c_fall: cover property (@(posedge CLK) rd_ok && fall_r[idx]);
    c_short: cover property (@(posedge CLK) set_ok && CMD.len == 3'd2);
endmodule : pgp_gpio_port

/* File: pgp_host_model.sv */
`timescale 1ns/1ns
module pgp_host_model
    import pgp_pkg::*;
(
    // host side
    input  wire logic clk,
    output logic      cmd_valid,
    output pgp_cmd_t  cmd
);
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end
    task automatic send(input pgp_cmd_t c);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd       = c;
        @(negedge clk);
        cmd_valid = 1'b0;
        // released bus shows garbage, not the old packet
        cmd       = ~c;
    endtask : send
endmodule : pgp_host_model

/* File: pgp_gpio_port_tb.sv */
`timescale 1ns/1ns
module pgp_gpio_port_tb;
    import pgp_pkg::*;
    localparam int STEP = 2;
    logic                     clk, rst, cmd_valid, resp_valid, boot_load;
    pgp_cmd_t                 cmd;
    pgp_resp_t                resp;
    logic [NUM_PINS-1:0][7:0] boot_level, save_level;
    logic [NUM_PINS-1:0][3:0] boot_cfg, save_cfg;
    logic [NUM_PINS-1:0]      dflt_out, dflt_oe, sample_lvl, ext, pin_i;
    logic [NUM_PINS-1:0]      pin_o, pin_oe, pin_pull, pin_slow;
    integer                   mismatches, samples_checked, seed, n, i, cnt;
    integer                   cycles = 0;
    logic [7:0]               lv;
    logic [2:0]               dm, pn;
    logic [1:0]               dp;
    logic [2:0]               dm_list [7] = '{3'd0, 3'd1, 3'd2, 3'd3,
                                               3'd4, 3'd5, 3'd7};
    logic [7:0]               lv_list [5] = '{8'd0, 8'd1, 8'd50, 8'd99,
                                               8'd100};

    // wire level: driven value wins over the outside world
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
    always #5 clk = ~clk;
    pgp_host_model u_pgp_host_model (.clk(clk), .cmd_valid(cmd_valid),
                                     .cmd(cmd));
    pgp_gpio_port #(.SAMPLE_DIV(10), .STEP_DIV(STEP)) u_pgp_gpio_port (
        .CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD(cmd),
        .RESP(resp), .RESP_VALID(resp_valid), .BOOT_LOAD(boot_load),
        .BOOT_LEVEL(boot_level), .BOOT_CFG(boot_cfg),
        .SAVE_LEVEL(save_level), .SAVE_CFG(save_cfg), .DFLT_OUT(dflt_out),
        .DFLT_OE(dflt_oe), .SAMPLE_LVL(sample_lvl), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULL(pin_pull),
        .PIN_SLOW(pin_slow));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic xfer(input logic [7:0] c, input logic [2:0] l,
                        input logic [7:0] a, b, d);
        u_pgp_host_model.send(pgp_cmd_t'{c, l, a, b, d});
        for (n = 0; n < 4 && resp_valid !== 1'b1; n++) @(negedge clk);
        check({7'h0, resp_valid}, 8'h01);
    endtask : xfer
    task automatic set_pin(input logic [7:0] idx, v, c, input logic [2:0] l,
                           input logic ok);
        xfer(CMD_SET_PIN, l, idx, v, c);
        check(resp.code, CMD_SET_PIN | (ok ? RESP_FLAG : RESP_NAK));
        check({5'h0, resp.len}, 8'h00);
    endtask : set_pin
    task automatic read_pin(input logic [7:0] idx, s, v, c, input logic chk);
        xfer(CMD_READ_PIN, 3'd1, idx, 8'h00, 8'h00);
        check(resp.code, CMD_READ_PIN | RESP_FLAG);
        check({5'h0, resp.len}, 8'h04);
        check(resp.d0, idx);
        if (chk) check(resp.d1, s);
        check(resp.d2, v);
        check(resp.d3, c);
    endtask : read_pin
    // {oe, pull} per drive mode for wanted level s
    function automatic logic [1:0] exp_drv(input logic [2:0] d,
                                           input logic s);
        case (d)
            3'b000: return s ? 2'b10 : 2'b01;
            3'b001, 3'b101: return 2'b10;
            3'b011: return s ? 2'b01 : 2'b10;
            3'b100: return {s, 1'b0};
            3'b111: return {~s, 1'b0};
            default: return 2'b00;
        endcase
    endfunction : exp_drv

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        clk = 0; rst = 1; boot_load = 0; ext = '0; dflt_out = '0;
        dflt_oe = '0; boot_level = '0; boot_cfg = '0;
        mismatches = 0; samples_checked = 0; seed = 60;
        repeat (5) @(negedge clk);
        rst = 0;
        read_pin(0, 8'h00, RST_LEVEL, {4'h0, RST_CFG}, 1);
        // let the first sample pass: it loads samp_r and arms edge capture, but flags no edge
        repeat (10) @(negedge clk);
        ext[0] = 1'b1;
        repeat (25) @(negedge clk);
        check({7'h0, sample_lvl[0]}, 8'h01);
        read_pin(0, 8'h05, 8'h00, 8'h02, 1);
        read_pin(0, 8'h01, 8'h00, 8'h02, 1);
        ext[0] = 1'b0;
        repeat (25) @(negedge clk);
        read_pin(0, 8'h02, 8'h00, 8'h02, 1);
        set_pin(5, 8'h0a, 8'h09, 3, 0);
        set_pin(1, 8'h65, 8'h09, 3, 0);
        set_pin(1, 8'h0a, 8'h10, 3, 0);
        set_pin(1, 8'h0a, 8'h0e, 3, 0);
        set_pin(1, 8'h0a, 8'h09, 1, 0);
        read_pin(1, 8'h00, RST_LEVEL, {4'h0, RST_CFG}, 0);
        xfer(CMD_READ_PIN, 3'd1, 8'h05, 8'h00, 8'h00);
        check(resp.code, CMD_READ_PIN | RESP_NAK);
        for (i = 0; i < 10; i++) begin
            pn = 3'($unsigned($random(seed)) % 4 + 1);
            lv = 8'($unsigned($random(seed)) % 101);
            dm = 3'($random(seed));
            if (dm == DRIVE_RSVD) dm = DRIVE_HIZ_IN;
            set_pin({5'h0, pn}, lv, {5'h01, dm}, 3, 1);
            read_pin({5'h0, pn}, 8'h00, lv, {5'h01, dm}, 0);
            set_pin({5'h0, pn}, LEVEL_HIGH - lv, 8'hff, 2, 1);
            read_pin({5'h0, pn}, 8'h00, LEVEL_HIGH - lv, {5'h01, dm}, 0);
        end
        foreach (dm_list[k]) begin
            for (i = 0; i < 2; i++) begin
                dm = dm_list[k];
                lv = i[0] ? LEVEL_HIGH : 8'h00;
                set_pin(3, lv, {5'h01, dm}, 3, 1);
                repeat (3) @(negedge clk);
                dp = exp_drv(dm, i[0]);
                check({7'h0, pin_o[3]}, {7'h0, i[0]});
                check({6'h0, pin_oe[3], pin_pull[3]}, {6'h0, dp});
                check({7'h0, pin_slow[3]}, {7'h0, dm[2]});
            end
        end
        foreach (lv_list[k]) begin
            lv = lv_list[k];
            set_pin(4, lv, 8'h09, 3, 1);
            repeat (4) @(negedge clk);
            cnt = 0;
            repeat (100 * STEP) @(negedge clk) cnt += pin_o[4];
            check(8'(cnt), 8'(lv * STEP));
        end
        set_pin(2, 8'h00, 8'h01, 3, 1);
        dflt_oe[2] = 1'b1;
        for (i = 0; i < 4; i++) begin
            dflt_out[2] = i[0];
            repeat (3) @(negedge clk);
            check({7'h0, pin_o[2]}, {7'h0, i[0]});
            check({7'h0, pin_oe[2]}, 8'h01);
        end
        dflt_oe[2] = 1'b0;
        repeat (3) @(negedge clk);
        check({7'h0, pin_oe[2]}, 8'h00);
        boot_level = {NUM_PINS{8'h1e}};
        boot_cfg = {NUM_PINS{4'h9}};
        boot_load = 1'b1;
        @(negedge clk);
        boot_load = 1'b0;
        repeat (3) @(negedge clk);
        check(save_level[3], 8'h1e);
        check({4'h0, save_cfg[3]}, 8'h09);
        read_pin(3, 8'h00, 8'h1e, 8'h09, 0);
        results();
    end
endmodule : pgp_gpio_port_tb
